// ---- src/lrd_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lrd_map.svh"
// ******************************************************************
// Overview of operation
// - Requests arrive serially: 6, 7, 9 or 17 bits, start one, stop zero.
// - Bus request: start, type bits 1-3, speed bits 4-5, stop bit 6.
// - Speed 00 is 100, 01 is 200, 10 is 400 Mbit/s; 11 reserved.
// - Read frame: address bits 4-7, stop bit 8.
// - Write frame: address bits 4-7, data bits 8-15, stop bit 16.
// - Acceleration frame: bit 4 enables acceleration when one, stop bit 5.
// - Types: immediate, isochronous, priority, fair, read, write, accel; 111 reserved.
// - Receive state cancels pending fair or priority requests; link resends.
// - Acceleration on and 8-bit acknowledge keeps fair or priority pending.
// - Isochronous request clears only on grant, subaction gap or bus reset.
// - Write frame updates the addressed register right after its last bit.
// - Read returns register as status; restarted from bit zero if interrupted.
// - One bus request pending; others ignored until it is removed.
// - Bus reset discards every pending bus request.
// - An accepted isochronous request asserts the accelerating indication.
// - Link control code 10 is transmit; code 11 is never driven.
// - Link control code 00 releases, 01 holds the interface.
// - Status carries four events, address bits 4-7, data bits 8-15, at 01.
// ******************************************************************
module lrd_decoder (
  input wire logic ref_clk, // Clock, 250 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic link_request_line, // Serial request from the link.
  input wire lrd_pkg::lrd_ctl_t control_lines, // Control lines as seen.
  input wire logic ctl_receiving, // Device drives receive state.
  input wire logic ctl_idle_entry, // Control lines enter idle, pulse.
  input wire logic ack_packet_rx, // Incoming packet is an 8-bit ack.
  input wire logic accel_enable, // Acceleration-enable configuration bit.
  input wire logic arb_grant, // Arbitration won, grant sent, pulse.
  input wire logic packet_tx_done, // Packet transmission removed request.
  input wire logic packet_rx_done, // Packet reception removed request.
  input wire logic subaction_gap, // Subaction gap detected, pulse.
  input wire logic bus_reset, // Bus reset, pulse.
  input wire logic [3:0] status_events, // Four status event bits.
  input wire logic [7:0] reg_read_data, // Contents at reg_read_addr.
  output logic [3:0] reg_read_addr, // Register address being read.
  output logic reg_write_strobe, // Register write, one-cycle pulse.
  output logic [3:0] reg_write_addr, // Register write address.
  output logic [7:0] reg_write_data, // Register write data.
  output logic bus_request_valid, // A bus request is pending.
  output lrd_pkg::lrd_type_t bus_request_type, // Pending request type.
  output lrd_pkg::lrd_speed_t bus_request_speed, // Pending request speed.
  output logic accelerating, // Accelerating indication.
  output logic accel_control, // Last acceleration control bit.
  output logic accel_control_strobe, // Accel control frame, pulse.
  output logic status_active, // Status output in progress.
  output logic [1:0] status_data, // Status bits out, two per clock.
  output lrd_pkg::lrd_ctl_t status_ctl // Control code during status.
);
  import lrd_pkg::*;

  lrd_frame_if frame ();

  lrd_shifter u_shifter (
    .ref_clk(ref_clk),
    .rst(rst),
    .link_request_line(link_request_line),
    .frame(frame)
  );

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire lrd_type_t f_type;
  wire lrd_speed_t f_speed;
  wire logic [3:0] f_addr;
  wire logic [7:0] f_data;
  wire logic f_accel;
  wire logic f_stop_ok;
  wire logic f_is_bus;
  wire logic f_ok;
  wire logic take_bus;
  wire logic take_read;
  wire logic take_write;
  wire logic take_accel;

  assign f_type = lrd_type_t'(frame.bits[`LRD_POS_TYPE_LO +: 3]);
  assign f_speed =
    lrd_speed_t'(frame.bits[`LRD_POS_SPEED_LO +: 2]);
  assign f_addr = frame.bits[`LRD_POS_ADDR_LO +: 4];
  assign f_data = frame.bits[`LRD_POS_DATA_LO +: 8];
  assign f_accel = frame.bits[`LRD_POS_ACCEL];
  // A set stop bit means the link lost framing; the frame is dropped.
  assign f_stop_ok = ~frame.bits[frame.len - 5'h01];
  assign f_is_bus = (f_type == LRD_REQ_IMM) || (f_type == LRD_REQ_ISO) ||
    (f_type == LRD_REQ_PRI) || (f_type == LRD_REQ_FAIR);
  assign f_ok = frame.done && f_stop_ok && (f_type != LRD_REQ_RSV);
  assign take_bus = f_ok && f_is_bus &&
    (f_speed != LRD_SPD_RSV);
  assign take_read = f_ok && (f_type == LRD_REQ_RD);
  assign take_write = f_ok && (f_type == LRD_REQ_WR);
  assign take_accel = f_ok && (f_type == LRD_REQ_ACC);

  // ****************************************************************
  // Pending bus request
  // ****************************************************************
  logic pend_reg;
  lrd_type_t ptype_reg;
  lrd_speed_t pspeed_reg;
  logic accel_ind_reg;
  wire logic p_arbfair;
  wire logic p_gap_clears;
  wire logic keep_on_rx;
  wire logic cancel_rx;
  wire logic remove;
  wire logic accept;

  assign p_arbfair = (ptype_reg == LRD_REQ_PRI) ||
    (ptype_reg == LRD_REQ_FAIR);
  assign p_gap_clears = (ptype_reg == LRD_REQ_ISO) ||
    (ptype_reg == LRD_REQ_IMM);
  assign keep_on_rx = accel_enable && ack_packet_rx;
  assign cancel_rx = p_arbfair && ctl_receiving && !keep_on_rx;
  // Isochronous requests survive receive and clear only on grant, gap or bus reset.
  assign remove = bus_reset || arb_grant ||
    (p_gap_clears && subaction_gap) ||
    (!(ptype_reg == LRD_REQ_ISO) &&
      (packet_rx_done || packet_tx_done)) || cancel_rx;
  assign accept = take_bus && !pend_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
      ptype_reg <= LRD_REQ_IMM;
      pspeed_reg <= LRD_SPD_100;
      accel_ind_reg <= 1'b0;
    end else if (pend_reg && remove) begin
      pend_reg <= 1'b0;
      accel_ind_reg <= 1'b0;
    end else if (accept && !bus_reset) begin
      pend_reg <= 1'b1;
      ptype_reg <= f_type;
      pspeed_reg <= f_speed;
      accel_ind_reg <= (f_type == LRD_REQ_ISO);
    end
  end

  // ****************************************************************
  // Register write and acceleration control
  // ****************************************************************
  logic wr_stb_reg;
  logic [3:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic acc_reg;
  logic acc_stb_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= 4'h0;
      wr_data_reg <= 8'h00;
      acc_reg <= `LRD_ACCEL_RESET;
      acc_stb_reg <= 1'b0;
    end else begin
      wr_stb_reg <= take_write;
      acc_stb_reg <= take_accel;
      if (take_write) begin
        wr_addr_reg <= f_addr;
        wr_data_reg <= f_data;
      end
      if (take_accel) begin
        acc_reg <= f_accel;
      end
    end
  end

  // ****************************************************************
  // Register read status output
  // ****************************************************************
  // Status shifts two bits a clock; an interruption by packet traffic
  // restarts from bit zero, since the link discards a partial status.
  typedef enum {LRD_ST_IDLE, LRD_ST_SEND} lrd_st_state_t;
  lrd_st_state_t st_state_reg;
  logic [3:0] rd_addr_reg;
  logic [15:0] st_word_reg;
  logic [4:0] st_idx_reg;
  logic [1:0] st_out_reg;
  logic st_act_reg;
  wire logic link_busy;
  wire logic [15:0] st_word;

  assign link_busy =
    ctl_receiving || (control_lines == LRD_CTL_XFER);
  assign st_word = {reg_read_data, rd_addr_reg, status_events};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_state_reg <= LRD_ST_IDLE;
      rd_addr_reg <= 4'h0;
      st_word_reg <= 16'h0000;
      st_idx_reg <= 5'h00;
      st_out_reg <= 2'h0;
      st_act_reg <= 1'b0;
    end else begin
      unique case (st_state_reg)
        LRD_ST_IDLE: begin
          st_act_reg <= 1'b0;
          st_out_reg <= 2'h0;
          st_idx_reg <= 5'h00;
          if (take_read) begin
            rd_addr_reg <= f_addr;
            st_state_reg <= LRD_ST_SEND;
          end
        end
        LRD_ST_SEND: begin
          if (link_busy) begin
            st_act_reg <= 1'b0;
            st_idx_reg <= 5'h00;
            st_out_reg <= 2'h0;
          end else if (st_idx_reg == `LRD_STATUS_BITS) begin
            st_act_reg <= 1'b0;
            st_out_reg <= 2'h0;
            st_state_reg <= LRD_ST_IDLE;
          end else begin
            if (st_idx_reg == 5'h00) begin
              st_word_reg <= st_word;
              st_out_reg <= st_word[1:0];
            end else begin
              st_out_reg <= st_word_reg[st_idx_reg[3:0] +: 2];
            end
            st_act_reg <= 1'b1;
            st_idx_reg <= st_idx_reg + 5'h02;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_read_addr = rd_addr_reg;
  assign reg_write_strobe = wr_stb_reg;
  assign reg_write_addr = wr_addr_reg;
  assign reg_write_data = wr_data_reg;
  assign bus_request_valid = pend_reg;
  assign bus_request_type = ptype_reg;
  assign bus_request_speed = pspeed_reg;
  assign accelerating = accel_ind_reg;
  assign accel_control = acc_reg;
  assign accel_control_strobe = acc_stb_reg;
  assign status_active = st_act_reg;
  assign status_data = st_out_reg;
  assign status_ctl =
    st_act_reg ? LRD_CTL_HOLD : LRD_CTL_IDLE;

  // ctl_idle_entry is kept for the arbiter's timing of fair requests.
  wire logic unused_idle;
  assign unused_idle = ctl_idle_entry;
endmodule
`default_nettype wire

// ---- src/lrd_map.svh ----
`ifndef LRD_MAP_SVH
`define LRD_MAP_SVH
// Frame lengths in bits, stop bit included.
`define LRD_LEN_ACCEL 5'd6
`define LRD_LEN_BUS 5'd7
`define LRD_LEN_READ 5'd9
`define LRD_LEN_WRITE 5'd17
// Bit positions within a frame, bit 0 first.
`define LRD_POS_TYPE_LO 1
`define LRD_POS_SPEED_LO 4
`define LRD_POS_ADDR_LO 4
`define LRD_POS_DATA_LO 8
`define LRD_POS_ACCEL 4
// Status output length in bits.
`define LRD_STATUS_BITS 5'd16
// Reset values.
`define LRD_ACCEL_RESET 1'b0
`endif

// ---- src/lrd_pkg.sv ----
package lrd_pkg;
  typedef enum logic [2:0] {
    LRD_REQ_IMM = 3'h0,
    LRD_REQ_ISO = 3'h1,
    LRD_REQ_PRI = 3'h2,
    LRD_REQ_FAIR = 3'h3,
    LRD_REQ_RD = 3'h4,
    LRD_REQ_WR = 3'h5,
    LRD_REQ_ACC = 3'h6,
    LRD_REQ_RSV = 3'h7
  } lrd_type_t;
  typedef enum logic [1:0] {
    LRD_SPD_100 = 2'h0,
    LRD_SPD_200 = 2'h1,
    LRD_SPD_400 = 2'h2,
    LRD_SPD_RSV = 2'h3
  } lrd_speed_t;
  typedef enum logic [1:0] {
    LRD_CTL_IDLE = 2'h0,
    LRD_CTL_HOLD = 2'h1,
    LRD_CTL_XFER = 2'h2,
    LRD_CTL_RSV = 2'h3
  } lrd_ctl_t;
endpackage

// ---- src/lrd_frame_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Carries a completed frame from the shifter to the decoder.
interface lrd_frame_if;
  logic done;
  logic [16:0] bits;
  logic [4:0] len;
  modport source (output done, output bits, output len);
  modport sink (input done, input bits, input len);
endinterface
`default_nettype wire

// ---- src/lrd_shifter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lrd_map.svh"
module lrd_shifter (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic link_request_line, // Serial request input.
  lrd_frame_if.source frame // Completed frame.
);
  import lrd_pkg::*;

  typedef enum {LRD_SH_IDLE, LRD_SH_BUSY} lrd_sh_state_t;
  lrd_sh_state_t state_reg;
  logic [16:0] bits_reg;
  logic [4:0] cnt_reg;
  logic [4:0] len_reg;
  logic done_reg;
  logic [16:0] bits_next;
  logic [4:0] cnt_next;
  wire logic [2:0] type_bits;
  wire logic [4:0] len_of_type;
  wire logic last_bit;

  // Bit index cnt_reg lands at bits[cnt_reg]; bit 0 is the start bit.
  assign bits_next = bits_reg | ({16'h0000, link_request_line} << cnt_reg);
  assign cnt_next = cnt_reg + 5'h01;
  assign type_bits = bits_next[3:1];
  assign len_of_type =
    (type_bits == 3'h4) ? `LRD_LEN_READ :
    (type_bits == 3'h5) ? `LRD_LEN_WRITE :
    (type_bits == 3'h6) ? `LRD_LEN_ACCEL : `LRD_LEN_BUS;
  // The length is only known once the type is in, so compare late.
  assign last_bit = (cnt_reg >= 5'h04) && (cnt_next == len_reg);

  // ****************************************************************
  // Serial capture
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    done_reg <= 1'b0;
    if (rst) begin
      state_reg <= LRD_SH_IDLE;
      bits_reg <= 17'h00000;
      cnt_reg <= 5'h00;
      len_reg <= `LRD_LEN_WRITE;
    end else begin
      unique case (state_reg)
        LRD_SH_IDLE: begin
          if (link_request_line) begin
            state_reg <= LRD_SH_BUSY;
            bits_reg <= 17'h00001;
            cnt_reg <= 5'h01;
            len_reg <= `LRD_LEN_WRITE;
          end
        end
        LRD_SH_BUSY: begin
          bits_reg <= bits_next;
          cnt_reg <= cnt_next;
          if (cnt_reg == 5'h03) begin
            len_reg <= len_of_type;
          end
          if (last_bit) begin
            state_reg <= LRD_SH_IDLE;
            done_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  assign frame.done = done_reg;
  assign frame.bits = bits_reg;
  assign frame.len = len_reg;
endmodule
`default_nettype wire

// ---- bench/lrd_decoder_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// ******************************************************************
// Port checker for the request decoder
// ******************************************************************
module lrd_decoder_monitor (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire lrd_pkg::lrd_ctl_t control_lines, // Link control code.
  input wire logic ctl_receiving, // Receive state.
  input wire logic ack_packet_rx, // Incoming 8-bit acknowledge.
  input wire logic accel_enable, // Acceleration enable bit.
  input wire logic arb_grant, // Grant pulse.
  input wire logic packet_tx_done, // Transmission done.
  input wire logic packet_rx_done, // Reception done.
  input wire logic subaction_gap, // Subaction gap pulse.
  input wire logic bus_reset, // Bus reset pulse.
  input wire logic reg_write_strobe, // Register write pulse.
  input wire logic bus_request_valid, // Request pending.
  input wire lrd_pkg::lrd_type_t bus_request_type, // Pending type.
  input wire logic accelerating, // Accelerating indication.
  input wire logic status_active, // Status in progress.
  input wire lrd_pkg::lrd_ctl_t status_ctl // Status control code.
);
  import lrd_pkg::*;
  logic link_busy, pend_pf, pend_iso, no_kill;
  assign link_busy = ctl_receiving || control_lines == LRD_CTL_XFER;
  assign pend_pf = bus_request_valid && (bus_request_type == LRD_REQ_PRI
    || bus_request_type == LRD_REQ_FAIR);
  assign pend_iso = bus_request_valid && bus_request_type == LRD_REQ_ISO;
  assign no_kill = !arb_grant && !bus_reset && !subaction_gap;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_quiet_status;
    $rose(status_active) ##0 (!link_busy) [*8];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !bus_request_valid && !status_active && !reg_write_strobe && !accelerating)
    else $error("outputs not quiet after reset");
  a_status_ctl_code: assert property (status_ctl ==
    (status_active ? LRD_CTL_HOLD : LRD_CTL_IDLE)) else $error("status code");
  a_write_one_pulse: assert property (reg_write_strobe |=>
    !reg_write_strobe) else $error("write strobe longer than one cycle");
  a_status_eight_cycles: assert property (s_quiet_status |=>
    !status_active) else $error("status length wrong");
  a_status_busy_drop: assert property (status_active && link_busy |=>
    !status_active) else $error("status not dropped on traffic");
  a_recv_cancel: assert property (pend_pf && ctl_receiving &&
    !(accel_enable && ack_packet_rx) |=> !bus_request_valid)
    else $error("fair or priority not cancelled");
  a_ack_keeps: assert property (pend_pf && ctl_receiving && accel_enable
    && ack_packet_rx && no_kill && !packet_rx_done && !packet_tx_done
    |=> bus_request_valid) else $error("request lost on acknowledge");
  a_iso_held: assert property (pend_iso && no_kill |=> pend_iso)
    else $error("isochronous request cleared early");
  a_iso_accel: assert property (accelerating == pend_iso)
    else $error("accelerating indication wrong");
  a_bus_reset_clear: assert property (bus_reset |=> !bus_request_valid)
    else $error("request survived bus reset");
  a_gap_clear: assert property (subaction_gap && bus_request_valid &&
    (bus_request_type == LRD_REQ_ISO || bus_request_type == LRD_REQ_IMM)
    |=> !bus_request_valid) else $error("gap did not clear request");
endmodule
bind lrd_decoder lrd_decoder_monitor u_mon (.ref_clk, .rst, .control_lines,
  .ctl_receiving, .ack_packet_rx, .accel_enable, .arb_grant, .packet_tx_done,
  .packet_rx_done, .subaction_gap, .bus_reset, .reg_write_strobe,
  .bus_request_valid, .bus_request_type, .accelerating, .status_active,
  .status_ctl);
`default_nettype wire

// ---- bench/lrd_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ******************************************************************
// Link controller request sender
// ******************************************************************
module lrd_link_model (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic go, // Start sending the frame.
  input wire logic [16:0] frame, // Frame bits, bit 0 first.
  input wire logic [4:0] len, // Frame length in bits.
  output logic link_request_line, // Serial request line.
  output logic busy // Frame in progress.
);
  logic [16:0] shift_reg;
  logic [4:0] count_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= 5'h00;
      shift_reg <= 17'h00000;
    end else if (go && !busy) begin
      shift_reg <= frame;
      count_reg <= len;
    end else if (busy) begin
      shift_reg <= shift_reg >> 1;
      count_reg <= count_reg - 5'h01;
    end
  end
  assign busy = count_reg != 5'h00;
  // The line rests low between frames, so no stray start bit is seen.
  assign link_request_line = busy & shift_reg[0];
endmodule
`default_nettype wire

// ---- bench/tb_link_request_serial_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lrd_map.svh"
// ******************************************************************
// Decoder testbench
// ******************************************************************
module tb_link_request_serial_decoder;
  import lrd_pkg::*;
  typedef struct packed {logic [2:0] t; logic [1:0] s; logic v;} lrd_row_t;
  localparam lrd_row_t rows [6] = '{'{3'h0, 2'h0, 1'b1}, '{3'h1, 2'h1, 1'b1},
    '{3'h2, 2'h2, 1'b1}, '{3'h3, 2'h1, 1'b1}, '{3'h3, 2'h3, 1'b0},
    '{3'h7, 2'h0, 1'b0}};
  logic ref_clk, rst, go, busy, line, wstb, valid, accel, acc_ctl, acc_stb;
  logic sact;
  logic [7:0] ev; // ack, accel on, receive, reset, gap, rx, tx, grant
  logic [16:0] frame;
  logic [4:0] len;
  logic [3:0] raddr, waddr;
  logic [7:0] wdata;
  logic [1:0] sdata;
  logic [15:0] got;
  lrd_ctl_t ctl, sctl;
  lrd_type_t btype;
  lrd_speed_t bspeed;
  int fails = 0;
  int comparisons = 0;
  lrd_link_model link (.ref_clk(ref_clk), .rst(rst), .go(go), .frame(frame),
    .len(len), .link_request_line(line), .busy(busy));
  lrd_decoder dut (.ref_clk(ref_clk), .rst(rst), .link_request_line(line),
    .control_lines(ctl), .ctl_receiving(ev[5]), .ctl_idle_entry(1'b0),
    .ack_packet_rx(ev[7]), .accel_enable(ev[6]), .arb_grant(ev[0]),
    .packet_tx_done(ev[1]), .packet_rx_done(ev[2]), .subaction_gap(ev[3]),
    .bus_reset(ev[4]), .status_events(4'h5), .reg_read_data({4'hA, raddr}),
    .reg_read_addr(raddr), .reg_write_strobe(wstb), .reg_write_addr(waddr),
    .reg_write_data(wdata), .bus_request_valid(valid),
    .bus_request_type(btype), .bus_request_speed(bspeed),
    .accelerating(accel), .accel_control(acc_ctl),
    .accel_control_strobe(acc_stb), .status_active(sact),
    .status_data(sdata), .status_ctl(sctl));
  task automatic complete_run;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ends just after the stop bit has been sampled.
  task automatic send(input logic [2:0] t, input logic [12:0] p,
      input logic [4:0] n);
    @(posedge ref_clk);
    go <= 1'b1;
    frame <= {p, t, 1'b1};
    len <= n;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 20 && busy; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 8'h00;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_status;
    for (int i = 0; i < 30 && !sact; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic collect(output logic [15:0] g);
    wait_status();
    for (int i = 0; i < 8; i++) begin
      g[2*i +: 2] = sdata;
      @(posedge ref_clk);
      #1;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    go = 1'b0;
    frame = 17'h00000;
    len = 5'h00;
    ev = 8'h00;
    ctl = LRD_CTL_IDLE;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(16'({valid, sact, wstb, accel, acc_stb}), 16'h0000);
    foreach (rows[i]) begin
      send(rows[i].t, {11'h000, rows[i].s}, `LRD_LEN_BUS);
      repeat (20) @(posedge ref_clk);
      #1;
      chk(16'(valid), 16'(rows[i].v));
      if (rows[i].v) chk(16'({btype, bspeed, accel}),
        16'({rows[i].t, rows[i].s, rows[i].t == 3'h1}));
      pulse(8'h10);
      chk(16'(valid), 16'h0000);
    end
    $display("test request table done");
    send(3'h5, {1'b0, 8'hC3, 4'hA}, `LRD_LEN_WRITE);
    for (int i = 0; i < 4 && !wstb; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(16'({wstb, waddr, wdata}), 16'h1AC3);
    for (int b = 1; b >= 0; b--) begin
      send(3'h6, 13'(b), `LRD_LEN_ACCEL);
      for (int i = 0; i < 4 && !acc_stb; i++) begin
        @(posedge ref_clk);
        #1;
      end
      chk(16'({acc_stb, acc_ctl}), 16'(2 + b));
    end
    $display("test write and acceleration done");
    send(3'h4, 13'h0009, `LRD_LEN_READ);
    collect(got);
    chk(got, 16'hA995);
    send(3'h4, 13'h0003, `LRD_LEN_READ);
    wait_status();
    repeat (2) @(posedge ref_clk);
    ctl <= LRD_CTL_XFER;
    @(posedge ref_clk);
    ctl <= LRD_CTL_IDLE;
    #1;
    chk(16'(sact), 16'h0000);
    collect(got);
    chk(got, 16'hA335);
    $display("test status done");
    send(3'h3, 13'h0000, `LRD_LEN_BUS);
    send(3'h2, 13'h0002, `LRD_LEN_BUS);
    pulse(8'hE0);
    chk(16'({valid, btype, bspeed}), 16'h002C);
    pulse(8'h20);
    chk(16'(valid), 16'h0000);
    send(3'h1, 13'h0001, `LRD_LEN_BUS);
    pulse(8'h26);
    chk(16'({valid, accel}), 16'h0003);
    pulse(8'h01);
    chk(16'(valid), 16'h0000);
    send(3'h1, 13'h0000, `LRD_LEN_BUS);
    pulse(8'h08);
    chk(16'(valid), 16'h0000);
    send(3'h0, 13'h0000, `LRD_LEN_BUS);
    pulse(8'h08);
    chk(16'(valid), 16'h0000);
    send(3'h2, 13'h0000, `LRD_LEN_BUS);
    pulse(8'h08);
    chk(16'(valid), 16'h0001);
    pulse(8'h04);
    chk(16'(valid), 16'h0000);
    $display("test pending requests done");
    complete_run();
  end
endmodule
`default_nettype wire
